// file: core/tcs_pkg.sv
package tcs_pkg;

	// command register location and field layout
	localparam logic [5:0] TCS_CMD_ADDR = 6'h00;
	localparam int TCS_PFX_HI = 7;
	localparam int TCS_PFX_LO = 6;
	localparam int TCS_NIB_HI = 7;
	localparam int TCS_NIB_LO = 4;
	localparam logic [3:0] TCS_NIB_ZERO = 4'h0;

	// lower nibble function codes
	localparam logic [3:0] TCS_C_STANDBY = 4'h0;
	localparam logic [3:0] TCS_C_RECEIVE = 4'h1;
	localparam logic [3:0] TCS_C_TRANSMIT = 4'h2;
	localparam logic [3:0] TCS_C_IDLE = 4'h3;
	localparam logic [3:0] TCS_C_IDLE_RET = 4'h4;
	localparam logic [3:0] TCS_C_NV_STORE = 4'h5;
	localparam logic [3:0] TCS_C_NV_RECALL = 4'h6;
	localparam logic [3:0] TCS_C_CAL_FAST = 4'h7;
	localparam logic [3:0] TCS_C_CAL_RC = 4'h8;
	localparam logic [3:0] TCS_C_CAL_PLL = 4'h9;
	localparam logic [3:0] TCS_C_CAL_AMP = 4'ha;
	localparam logic [3:0] TCS_C_ROM_COPY = 4'hb;
	localparam logic [3:0] TCS_C_GLOBAL_RST = 4'hf;

	// adc command prefixes and the loop filter channel
	localparam logic [1:0] TCS_ADC_ONCE = 2'h1;
	localparam logic [1:0] TCS_ADC_CONT = 2'h3;
	localparam logic [5:0] TCS_ADC_LOOP_FILTER = 6'h20;

	// neighbour channel table: four below, four above, 300 kHz apart
	localparam int TCS_CHAN_HALF = 4;
	localparam int TCS_CHAN_NUM = 2 * TCS_CHAN_HALF;
	localparam int TCS_CHAN_STEP_KHZ = 300;
	localparam int TCS_REF_KHZ = 24000;
	localparam int TCS_FRAC_SCALE = 262147;
	localparam logic [31:0] TCS_CHAN_STEP =
		32'((64'(TCS_CHAN_STEP_KHZ) * 64'(TCS_FRAC_SCALE)) / 64'(TCS_REF_KHZ));
	localparam logic [2:0] TCS_CHAN_LAST = 3'(TCS_CHAN_NUM - 1);
	localparam logic [2:0] TCS_CHAN_MID = 3'(TCS_CHAN_HALF - 1);

	// register write strobe with address and data
	typedef struct packed {
		logic wr;
		logic [5:0] addr;
		logic [7:0] data;
	} tcs_wr_t;

	// start request for a finite task engine
	typedef struct packed {
		logic go;
		logic [3:0] code;
	} tcs_task_t;

	// start request for the converter
	typedef struct packed {
		logic go;
		logic [5:0] chan;
	} tcs_adc_t;

	typedef enum logic [2:0] {
		TCS_M_STANDBY, TCS_M_RECEIVE, TCS_M_TRANSMIT, TCS_M_IDLE, TCS_M_TASK, TCS_M_ADC
	} tcs_mode_t;

	typedef enum logic [3:0] {
		TCS_S_STANDBY, TCS_S_RECEIVE, TCS_S_TRANSMIT, TCS_S_IDLE, TCS_S_TASK,
		TCS_S_ROM, TCS_S_CHAN, TCS_S_ADC_ONCE, TCS_S_ADC_CONT, TCS_S_RESET
	} tcs_state_t;

endpackage

// file: core/tcs_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module tcs_sequencer
	import tcs_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST_B,
	input wire tcs_wr_t REG_WR,
	input wire logic STBY_CLOCK_ONLY,
	input wire logic TASK_DONE,
	input wire logic ADC_DONE,
	input wire logic [31:0] CENTER_WORD,
	input wire logic [2:0] CHAN_IDX,
	output tcs_mode_t MODE,
	output logic BUSY,
	output logic INSTR_EN,
	output logic SYSTEM_CLOCK_OUTPUT_EN,
	output logic XTAL_EN,
	output tcs_task_t TASK_REQ,
	output tcs_adc_t ADC_REQ,
	output logic GLOBAL_RESET,
	output logic [31:0] LO_WORD,
	output logic [31:0] CHAN_WORD
);

	// decoding helpers
	function automatic logic is_func(input logic [7:0] c);
		return c[TCS_NIB_HI:TCS_NIB_LO] == TCS_NIB_ZERO;
	endfunction

	function automatic logic is_finite_code(input logic [3:0] n);
		return n inside {TCS_C_NV_STORE, TCS_C_NV_RECALL, TCS_C_CAL_FAST,
			TCS_C_CAL_RC, TCS_C_CAL_PLL, TCS_C_CAL_AMP};
	endfunction

	tcs_state_t state_q, state_d;
	logic [3:0] code_q, code_d;
	logic [5:0] chan_sel_q, chan_sel_d;
	logic [2:0] cidx_q, cidx_d;
	logic [31:0] acc_q, acc_d;
	logic [31:0] chan_q [TCS_CHAN_NUM];
	logic busy_q;
	logic task_go_d;
	logic adc_go_d;

	// command write decode
	wire cmd_wr = REG_WR.wr && REG_WR.addr == TCS_CMD_ADDR;
	wire [7:0] cmd = REG_WR.data;
	wire [3:0] nib = cmd[TCS_NIB_LO-1:0];
	wire [1:0] pfx = cmd[TCS_PFX_HI:TCS_PFX_LO];
	wire f_ok = is_func(cmd);
	wire c_stby = f_ok && nib == TCS_C_STANDBY;
	wire c_rx = f_ok && nib == TCS_C_RECEIVE;
	wire c_tx = f_ok && nib == TCS_C_TRANSMIT;
	wire c_idle = f_ok && (nib == TCS_C_IDLE || nib == TCS_C_IDLE_RET);
	wire c_fin = f_ok && is_finite_code(nib);
	wire c_rom = f_ok && nib == TCS_C_ROM_COPY;
	wire c_grst = f_ok && nib == TCS_C_GLOBAL_RST;
	wire c_adc1 = pfx == TCS_ADC_ONCE;
	wire c_adcc = pfx == TCS_ADC_CONT;
	wire c_known = c_stby | c_rx | c_tx | c_idle | c_fin | c_rom | c_grst | c_adc1 | c_adcc;
	// receive and transmit wait for stand-by; global reset bypasses busy
	wire live_now = state_q inside {TCS_S_RECEIVE, TCS_S_TRANSMIT};
	wire take = cmd_wr && c_known
		&& (c_grst || (!busy_q && (!live_now || c_stby)));
	wire chan_end = state_q == TCS_S_CHAN && cidx_q == TCS_CHAN_LAST;

	// next state and request decode
	always_comb begin
		state_d = state_q;
		code_d = code_q;
		chan_sel_d = chan_sel_q;
		cidx_d = cidx_q;
		acc_d = acc_q;
		task_go_d = 1'b0;
		adc_go_d = 1'b0;
		if (take) begin
			code_d = nib;
			chan_sel_d = cmd[TCS_PFX_LO-1:0];
			if (c_grst) begin
				state_d = TCS_S_RESET;
			end else if (c_adc1) begin
				state_d = TCS_S_ADC_ONCE;
				adc_go_d = 1'b1;
			end else if (c_adcc) begin
				state_d = TCS_S_ADC_CONT;
				adc_go_d = 1'b1;
			end else if (c_stby) begin
				state_d = TCS_S_STANDBY;
			end else if (c_rx) begin
				state_d = TCS_S_RECEIVE;
			end else if (c_tx) begin
				state_d = TCS_S_TRANSMIT;
			end else if (c_idle) begin
				state_d = TCS_S_IDLE;
			end else if (c_rom) begin
				state_d = TCS_S_ROM;
				task_go_d = 1'b1;
			end else begin
				state_d = TCS_S_TASK;
				task_go_d = 1'b1;
			end
		end else begin
			case (state_q)
				TCS_S_TASK: begin
					if (TASK_DONE) begin
						state_d = TCS_S_STANDBY;
					end
				end
				TCS_S_ROM: begin
					if (TASK_DONE) begin
						state_d = TCS_S_CHAN;
						cidx_d = '0;
						acc_d = CENTER_WORD - 32'(TCS_CHAN_HALF) * TCS_CHAN_STEP;
					end
				end
				TCS_S_CHAN: begin
					cidx_d = cidx_q + 3'h1;
					// skip over the centre itself between the lower and upper halves
					acc_d = acc_q + ((cidx_q == TCS_CHAN_MID) ? (TCS_CHAN_STEP << 1)
						: TCS_CHAN_STEP);
					if (chan_end) begin
						state_d = TCS_S_STANDBY;
					end
				end
				TCS_S_ADC_ONCE: begin
					if (ADC_DONE) begin
						state_d = TCS_S_STANDBY;
					end
				end
				TCS_S_ADC_CONT: begin
					adc_go_d = ADC_DONE;
				end
				TCS_S_RESET: begin
					state_d = TCS_S_STANDBY;
				end
				default: begin
					state_d = state_q;
				end
			endcase
		end
	end

	wire busy_d = state_d inside {TCS_S_TASK, TCS_S_ROM, TCS_S_CHAN, TCS_S_ADC_ONCE,
		TCS_S_RESET};
	wire stby_d = state_d == TCS_S_STANDBY;
	wire live_d = state_d inside {TCS_S_RECEIVE, TCS_S_TRANSMIT};

	// mode presented to the analog side
	tcs_mode_t mode_d;
	always_comb begin
		case (state_d)
			TCS_S_STANDBY: mode_d = TCS_M_STANDBY;
			TCS_S_RECEIVE: mode_d = TCS_M_RECEIVE;
			TCS_S_TRANSMIT: mode_d = TCS_M_TRANSMIT;
			TCS_S_IDLE: mode_d = TCS_M_IDLE;
			TCS_S_ADC_ONCE, TCS_S_ADC_CONT: mode_d = TCS_M_ADC;
			default: mode_d = TCS_M_TASK;
		endcase
	end

	// sequencer state
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			state_q <= TCS_S_STANDBY;
			code_q <= TCS_C_STANDBY;
			chan_sel_q <= '0;
			cidx_q <= '0;
			acc_q <= '0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			code_q <= code_d;
			chan_sel_q <= chan_sel_d;
			cidx_q <= cidx_d;
			acc_q <= acc_d;
			busy_q <= busy_d;
		end
	end

	// registered outputs
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			MODE <= TCS_M_STANDBY;
			BUSY <= 1'b0;
			INSTR_EN <= 1'b1;
			SYSTEM_CLOCK_OUTPUT_EN <= 1'b0;
			XTAL_EN <= 1'b0;
			TASK_REQ <= '0;
			ADC_REQ <= '0;
			GLOBAL_RESET <= 1'b0;
		end else begin
			MODE <= mode_d;
			BUSY <= busy_d;
			INSTR_EN <= !busy_d;
			SYSTEM_CLOCK_OUTPUT_EN <= (stby_d && STBY_CLOCK_ONLY) || live_d;
			XTAL_EN <= state_d != TCS_S_IDLE && !(stby_d && !STBY_CLOCK_ONLY);
			TASK_REQ.go <= task_go_d;
			TASK_REQ.code <= code_d;
			ADC_REQ.go <= adc_go_d;
			ADC_REQ.chan <= chan_sel_d;
			GLOBAL_RESET <= state_d == TCS_S_RESET;
		end
	end

	// neighbour channel table, cleared by global reset
	genvar gi;
	generate
		for (gi = 0; gi < TCS_CHAN_NUM; gi++) begin : g_chan
			always_ff @(posedge MCLK or negedge RST_B) begin
				if (!RST_B) begin
					chan_q[gi] <= '0;
				end else if (state_q == TCS_S_RESET) begin
					chan_q[gi] <= '0;
				end else if (state_q == TCS_S_CHAN && cidx_q == 3'(gi)) begin
					chan_q[gi] <= acc_q;
				end
			end
		end
	endgenerate

	// one frequency word for both directions, table readout
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			LO_WORD <= '0;
			CHAN_WORD <= '0;
		end else begin
			LO_WORD <= CENTER_WORD;
			CHAN_WORD <= chan_q[CHAN_IDX];
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);

	sequence s_take_rx;
		take && REG_WR.data == {TCS_NIB_ZERO, TCS_C_RECEIVE};
	endsequence
	sequence s_rx_held;
		MODE == TCS_M_RECEIVE [*2];
	endsequence

	a_rx_entry_held: assert property (
		s_take_rx ##1 !cmd_wr [*2] |-> s_rx_held)
		else $error("receive command did not hold receive mode");

	a_busy_drop: assert property (
		cmd_wr && busy_q && REG_WR.data != {TCS_NIB_ZERO, TCS_C_GLOBAL_RST}
			|=> $stable(code_q) && $stable(chan_sel_q) && !TASK_REQ.go && !ADC_REQ.go)
		else $error("command accepted while busy");

	a_busy_flag: assert property (
		BUSY == (state_q inside {TCS_S_TASK, TCS_S_ROM, TCS_S_CHAN, TCS_S_ADC_ONCE,
			TCS_S_RESET}))
		else $error("busy flag does not track task state");

	a_ready_flag: assert property (INSTR_EN == !BUSY)
		else $error("instruction enable not inverse of busy");

	a_task_return: assert property (
		state_q == TCS_S_TASK && TASK_DONE && !cmd_wr |=> MODE == TCS_M_STANDBY)
		else $error("finite task did not return to stand-by");

	a_chan_len: assert property (
		state_q == TCS_S_ROM && TASK_DONE && !cmd_wr |=> state_q == TCS_S_CHAN [*8]
			##1 state_q == TCS_S_STANDBY)
		else $error("channel table not eight cycles long");

	a_chan_step: assert property (
		state_q == TCS_S_CHAN && cidx_q == TCS_CHAN_LAST |=>
			chan_q[TCS_CHAN_LAST] - chan_q[0] == 32'(TCS_CHAN_NUM) * TCS_CHAN_STEP)
		else $error("channel table span wrong");

	a_idle_noclk: assert property (
		MODE == TCS_M_IDLE |-> !SYSTEM_CLOCK_OUTPUT_EN)
		else $error("system clock output running in idle");

	a_grst_pulse: assert property (
		cmd_wr && REG_WR.data == {TCS_NIB_ZERO, TCS_C_GLOBAL_RST} ##1 !cmd_wr
			|-> GLOBAL_RESET ##1 !GLOBAL_RESET && MODE == TCS_M_STANDBY)
		else $error("global reset pulse malformed");

	a_bad_ignored: assert property (
		cmd_wr && !c_known
			|=> $stable(code_q) && $stable(chan_sel_q) && !TASK_REQ.go)
		else $error("unlisted command changed mode");

	a_adc_once: assert property (
		cmd_wr && !BUSY && !live_now && pfx == TCS_ADC_ONCE |=> ADC_REQ.go && MODE == TCS_M_ADC)
		else $error("single conversion not started");

	a_live_hold: assert property (
		state_q inside {TCS_S_RECEIVE, TCS_S_TRANSMIT} && cmd_wr
			&& REG_WR.data != {TCS_NIB_ZERO, TCS_C_STANDBY}
			&& REG_WR.data != {TCS_NIB_ZERO, TCS_C_GLOBAL_RST} |=> $stable(state_q))
		else $error("live mode left without stand-by command");

	a_stby_clock: assert property (
		$past(RST_B) && MODE == TCS_M_STANDBY
			|-> {SYSTEM_CLOCK_OUTPUT_EN, XTAL_EN} == {2{$past(STBY_CLOCK_ONLY)}})
		else $error("stand-by clock enables do not follow options bit");

	a_live_clock: assert property (
		MODE inside {TCS_M_RECEIVE, TCS_M_TRANSMIT} |-> SYSTEM_CLOCK_OUTPUT_EN && XTAL_EN)
		else $error("clock enables low in receive or transmit");

	a_idle_xtal: assert property (
		MODE == TCS_M_IDLE |-> !XTAL_EN)
		else $error("crystal running in idle");

	a_task_pulse: assert property (
		TASK_REQ.go |=> !TASK_REQ.go)
		else $error("task start longer than one cycle");

	a_cont_repeat: assert property (
		state_q == TCS_S_ADC_CONT && ADC_DONE && !cmd_wr |=> ADC_REQ.go)
		else $error("continuous conversion not restarted");

endmodule // tcs_sequencer
`default_nettype wire

// file: testbench/tcs_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
module tcs_engine_model
	import tcs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire tcs_task_t task_req,
	input wire tcs_adc_t adc_req,
	input wire logic glb_rst,
	input wire logic [4:0] delay,
	output logic task_done,
	output logic adc_done
);
	logic [4:0] tcnt_q;
	logic [4:0] acnt_q;
	logic tact_q;
	logic aact_q;

	// done pulses fire when the countdown hits zero
	assign task_done = tact_q && (tcnt_q == 5'h00);
	assign adc_done = aact_q && (acnt_q == 5'h00);

	// countdown per engine, cleared by chip reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tact_q <= 1'b0;
			aact_q <= 1'b0;
			tcnt_q <= 5'h00;
			acnt_q <= 5'h00;
		end else if (glb_rst) begin
			tact_q <= 1'b0;
			aact_q <= 1'b0;
			tcnt_q <= 5'h00;
			acnt_q <= 5'h00;
		end else begin
			if (task_req.go) begin
				tact_q <= 1'b1;
				tcnt_q <= delay;
			end else if (tact_q) begin
				tact_q <= (tcnt_q != 5'h00);
				tcnt_q <= tcnt_q - 5'h01;
			end
			if (adc_req.go) begin
				aact_q <= 1'b1;
				acnt_q <= delay;
			end else if (aact_q) begin
				aact_q <= (acnt_q != 5'h00);
				acnt_q <= acnt_q - 5'h01;
			end
		end
	end
endmodule // tcs_engine_model
`default_nettype wire

// file: testbench/tcs_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tcs_sequencer_tb_top
	import tcs_pkg::*;
;
	logic MCLK, RST_B, STBY_CLOCK_ONLY, TASK_DONE, ADC_DONE, GLOBAL_RESET;
	logic BUSY, INSTR_EN, SYSTEM_CLOCK_OUTPUT_EN, XTAL_EN;
	tcs_wr_t REG_WR;
	logic [31:0] CENTER_WORD, LO_WORD, CHAN_WORD;
	logic [2:0] CHAN_IDX;
	tcs_mode_t MODE;
	tcs_task_t TASK_REQ;
	tcs_adc_t ADC_REQ;
	logic [4:0] delay;
	int err_total, checked, n, k;
	logic [7:0] bad [6] = '{8'h0c, 8'h0d, 8'h0e, 8'h12, 8'h80, 8'h9b};

	tcs_sequencer tcs_sequencer_inst (.MCLK, .RST_B, .REG_WR, .STBY_CLOCK_ONLY, .TASK_DONE,
		.ADC_DONE, .CENTER_WORD, .CHAN_IDX, .MODE, .BUSY, .INSTR_EN, .SYSTEM_CLOCK_OUTPUT_EN,
		.XTAL_EN, .TASK_REQ, .ADC_REQ, .GLOBAL_RESET, .LO_WORD, .CHAN_WORD);
	tcs_engine_model tcs_engine_model_inst (.clk(MCLK), .rst_b(RST_B), .task_req(TASK_REQ),
		.adc_req(ADC_REQ), .glb_rst(GLOBAL_RESET), .delay(delay), .task_done(TASK_DONE),
		.adc_done(ADC_DONE));

	// clock
	initial begin
		MCLK = 1'b0;
		forever #2 MCLK = ~MCLK;
	end

	task automatic stop_test();
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic step(input int c);
		repeat (c) @(posedge MCLK);
		#1;
	endtask

	// one idle cycle, then a one-cycle write to the command register
	task automatic wr_cmd(input logic [7:0] d);
		step(1);
		REG_WR = '{wr: 1'b1, addr: TCS_CMD_ADDR, data: d};
		step(1);
		REG_WR.wr = 1'b0;
	endtask

	// host polls busy and instruction enable before a command
	task automatic wait_free();
		int i;
		i = 0;
		while ((BUSY !== 1'b0 || INSTR_EN !== 1'b1) && i < 200) begin
			step(1);
			i++;
		end
		if (i >= 200) begin
			err_total++;
			stop_test();
		end
	endtask

	// main sequence
	initial begin
		RST_B = 1'b0;
		REG_WR = '0;
		STBY_CLOCK_ONLY = 1'b1;
		CENTER_WORD = 32'h26fe_9554;
		CHAN_IDX = 3'h0;
		delay = 5'h06;
		repeat (3) @(posedge MCLK);
		#1 RST_B = 1'b1;
		step(1);
		check(32'(MODE), 32'(TCS_M_STANDBY));
		check(32'(BUSY), 32'h0);
		check(32'(INSTR_EN), 32'h1);
		check(32'({SYSTEM_CLOCK_OUTPUT_EN, XTAL_EN}), 32'h3);
		STBY_CLOCK_ONLY = 1'b0;
		step(1);
		check(32'({SYSTEM_CLOCK_OUTPUT_EN, XTAL_EN}), 32'h0);
		wr_cmd(8'h01);
		check(32'(MODE), 32'(TCS_M_RECEIVE));
		check(32'(SYSTEM_CLOCK_OUTPUT_EN), 32'h1);
		step(2);
		for (k = 0; k < 6; k++) begin
			wr_cmd(bad[k]);
			check(32'({MODE, TASK_REQ.go, ADC_REQ.go}), {27'h0, TCS_M_RECEIVE, 2'b00});
		end
		step(5);
		check(32'(MODE), 32'(TCS_M_RECEIVE));
		wr_cmd(8'h02);
		check(32'(MODE), 32'(TCS_M_RECEIVE));
		wr_cmd(8'h00);
		check(32'(MODE), 32'(TCS_M_STANDBY));
		wr_cmd(8'h02);
		check(32'(MODE), 32'(TCS_M_TRANSMIT));
		wr_cmd(8'h03);
		check(32'(MODE), 32'(TCS_M_TRANSMIT));
		wr_cmd(8'h00);
		wr_cmd(8'h03);
		check(32'(MODE), 32'(TCS_M_IDLE));
		check(32'({SYSTEM_CLOCK_OUTPUT_EN, XTAL_EN}), 32'h0);
		wr_cmd(8'h00);
		check(32'(MODE), 32'(TCS_M_STANDBY));
		wr_cmd(8'h04);
		check(32'(MODE), 32'(TCS_M_IDLE));
		wr_cmd(8'h00);
		// every finite task code and the ROM copy, with a refused write while busy
		for (n = 5; n <= 11; n++) begin
			wait_free();
			wr_cmd(8'(n));
			check(32'({TASK_REQ.go, TASK_REQ.code}), 32'(16 + n));
			check(32'({MODE, BUSY, INSTR_EN}), {27'h0, TCS_M_TASK, 2'b10});
			step(1);
			check(32'(TASK_REQ.go), 32'h0);
			wr_cmd(8'h01);
			check(32'(MODE), 32'(TCS_M_TASK));
			wait_free();
			check(32'(MODE), 32'(TCS_M_STANDBY));
		end
		check(LO_WORD, CENTER_WORD);
		for (k = 0; k < 8; k++) begin
			CHAN_IDX = 3'(k);
			step(1);
			check(CHAN_WORD, CENTER_WORD + 32'((k < 4 ? k - 4 : k - 3) * 3276));
		end
		wr_cmd(8'h60);
		check(32'({ADC_REQ, MODE, BUSY}), {21'h0, 1'b1, 6'h20, TCS_M_ADC, 1'b1});
		wait_free();
		check(32'(MODE), 32'(TCS_M_STANDBY));
		// continuous conversions until the next command
		wr_cmd(8'he5);
		check(32'({ADC_REQ, BUSY}), {24'h0, 1'b1, 6'h25, 1'b0});
		n = 0;
		repeat (30) begin
			step(1);
			if (ADC_REQ.go === 1'b1) n++;
		end
		check(32'(n >= 2), 32'h1);
		wr_cmd(8'h00);
		check(32'(MODE), 32'(TCS_M_STANDBY));
		// global reset taken while busy
		wr_cmd(8'h07);
		wr_cmd(8'h0f);
		check(32'(GLOBAL_RESET), 32'h1);
		step(1);
		check(32'({GLOBAL_RESET, MODE, BUSY}), {28'h0, TCS_M_STANDBY, 1'b0});
		step(1);
		check(CHAN_WORD, 32'h0);
		stop_test();
	end
endmodule // tcs_sequencer_tb_top
`default_nettype wire
